// ---- logic/pcie_link_cap_config_regs.sv ----
// Link capability configuration register bank with strobed register port
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module pcie_link_cap_config_regs #(
    parameter logic       ROUTING_ID_EN = 1'b0,
    parameter logic [1:0] FUNC_NUM      = 2'd0,
    parameter logic [3:0] MAX_SPEED     = 4'h3,
    parameter logic       TPH_REQ_CAP   = 1'b0,
    parameter logic       ATS_CAP       = 1'b0,
    parameter logic [3:0] CPL_TO_RANGES = 4'h0,
    parameter logic       CPL_TO_DIS_OK = 1'b1,
    parameter logic [2:0] SPEEDS_SUPP   = 3'h7,
    parameter logic       SLOT_CLK_CFG  = 1'b0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Link training status, same clock
    input  wire logic [3:0]  neg_speed,
    input  wire logic [5:0]  neg_width,
    input  wire logic [3:0]  eq_status,
    input  wire logic        eq_request,
    // Control outputs
    output logic             atomic_req_en,
    output logic             hw_speed_disable
);
    cfg_bus_if cfg ();

    logic [31:0] link_ctl;
    logic [31:0] dev_ctl2;
    logic [31:0] link_ctl2;
    logic [9:0]  link_sts;
    logic [3:0]  eq_sts;
    logic        eq_req_flag;
    logic [31:0] next_link_ctl;
    logic [31:0] next_dev_ctl2;
    logic [31:0] next_link_ctl2;
    logic [9:0]  next_link_sts;
    logic [3:0]  next_eq_sts;
    logic        next_eq_req_flag;
    logic [31:0] next_reg_rdata;
    logic [31:0] rd_value;

    assign cfg.routing_id_en = ROUTING_ID_EN;
    assign cfg.func_num      = FUNC_NUM;
    assign cfg.max_speed     = MAX_SPEED;
    assign cfg.tph_req_cap   = TPH_REQ_CAP;
    assign cfg.ats_cap       = ATS_CAP;

    next_ptr_select u_sel (
        .cfg (cfg)
    );

    // Read mux
    always_comb begin
        if (reg_addr == cfg_regs_pkg::OFF_LINK_CTL) begin
            rd_value = link_ctl;
            rd_value[cfg_regs_pkg::POS_NEG_WIDTH +: 6] = link_sts[9:4];
            rd_value[cfg_regs_pkg::POS_NEG_SPEED +: 4] = link_sts[3:0];
            rd_value[cfg_regs_pkg::POS_SLOT_CLK] = SLOT_CLK_CFG;
        end else if (reg_addr == cfg_regs_pkg::OFF_DEV_CAP2) begin
            rd_value = {27'h000_0000, CPL_TO_DIS_OK, CPL_TO_RANGES};
        end else if (reg_addr == cfg_regs_pkg::OFF_DEV_CTL2) begin
            rd_value = dev_ctl2;
        end else if (reg_addr == cfg_regs_pkg::OFF_LINK_CAP2) begin
            rd_value = {28'h000_0000, SPEEDS_SUPP, 1'b0};
        end else if (reg_addr == cfg_regs_pkg::OFF_LINK_CTL2) begin
            rd_value = link_ctl2;
            rd_value[cfg_regs_pkg::POS_EQ_DONE +: 4] = eq_sts;
            rd_value[cfg_regs_pkg::BIT_LEQ_REQ] = eq_req_flag;
        end else if (reg_addr == cfg_regs_pkg::OFF_ERR_HDR) begin
            rd_value = {cfg.next_ptr, cfg_regs_pkg::CAP_VERSION, cfg_regs_pkg::EXT_CAP_ID};
        end else begin
            rd_value = 32'h0000_0000;
        end
    end

    // Next state
    always_comb begin
        next_link_ctl    = link_ctl;
        next_dev_ctl2    = dev_ctl2;
        next_link_ctl2   = link_ctl2;
        next_link_sts    = {neg_width, neg_speed};
        next_eq_sts      = eq_status;
        next_eq_req_flag = eq_req_flag;
        next_reg_rdata   = 32'h0000_0000;
        if (reg_read) begin
            next_reg_rdata = rd_value;
        end
        if (reg_write) begin
            if (reg_addr == cfg_regs_pkg::OFF_LINK_CTL) begin
                next_link_ctl = reg_wdata & cfg_regs_pkg::MASK_LINK_CTL;
            end else if (reg_addr == cfg_regs_pkg::OFF_DEV_CTL2) begin
                next_dev_ctl2 = reg_wdata & cfg_regs_pkg::MASK_DEV_CTL2;
            end else if (reg_addr == cfg_regs_pkg::OFF_LINK_CTL2) begin
                next_link_ctl2 = reg_wdata & cfg_regs_pkg::MASK_LINK_CTL2;
                if (reg_wdata[cfg_regs_pkg::BIT_LEQ_REQ]) begin
                    next_eq_req_flag = 1'b0;
                end
            end
        end
        // Set wins over clear
        if (eq_request) begin
            next_eq_req_flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            link_ctl         <= cfg_regs_pkg::RST_LINK_CTL;
            dev_ctl2         <= cfg_regs_pkg::RST_DEV_CTL2;
            link_ctl2        <= cfg_regs_pkg::RST_LINK_CTL2;
            link_sts         <= 10'h000;
            eq_sts           <= 4'h0;
            eq_req_flag      <= 1'b0;
            reg_rdata        <= 32'h0000_0000;
            atomic_req_en    <= 1'b0;
            hw_speed_disable <= 1'b0;
        end else if (clk_en) begin
            link_ctl         <= next_link_ctl;
            dev_ctl2         <= next_dev_ctl2;
            link_ctl2        <= next_link_ctl2;
            link_sts         <= next_link_sts;
            eq_sts           <= next_eq_sts;
            eq_req_flag      <= next_eq_req_flag;
            reg_rdata        <= next_reg_rdata;
            atomic_req_en    <= next_dev_ctl2[6];
            hw_speed_disable <= next_link_ctl2[5];
        end
    end

    // Assertions
    property p_hdr_id;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR)
            |=> reg_rdata[15:0] == 16'h0001;
    endproperty
    a_hdr_id: assert property (p_hdr_id) else $error("Header id wrong");

    property p_ptr_route;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && ROUTING_ID_EN)
            |=> reg_rdata[31:20] == 12'h160;
    endproperty
    a_ptr_route: assert property (p_ptr_route) else $error("Routing pointer wrong");

    property p_ptr_gen3;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && FUNC_NUM == 2'd0 && MAX_SPEED == 4'h3) |=> reg_rdata[31:20] == 12'h280;
    endproperty
    a_ptr_gen3: assert property (p_ptr_gen3) else $error("Secondary pointer wrong");

    property p_ptr_tph;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && MAX_SPEED != 4'h3 && TPH_REQ_CAP) |=> reg_rdata[31:20] == 12'h300;
    endproperty
    a_ptr_tph: assert property (p_ptr_tph) else $error("TPH pointer wrong");

    property p_ptr_ats;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && MAX_SPEED != 4'h3 && !TPH_REQ_CAP && ATS_CAP) |=> reg_rdata[31:20] == 12'h3c0;
    endproperty
    a_ptr_ats: assert property (p_ptr_ats) else $error("ATS pointer wrong");

    property p_ptr_end;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && !TPH_REQ_CAP && !ATS_CAP && (FUNC_NUM != 2'd0 || MAX_SPEED != 4'h3))
            |=> reg_rdata[31:20] == 12'h000;
    endproperty
    a_ptr_end: assert property (p_ptr_end) else $error("End pointer wrong");

    property p_atomic;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_DEV_CTL2)
            |=> atomic_req_en == $past(reg_wdata[6]);
    endproperty
    a_atomic: assert property (p_atomic) else $error("Atomic enable not stored");

    property p_hasd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_LINK_CTL2)
            |=> hw_speed_disable == $past(reg_wdata[5]);
    endproperty
    a_hasd: assert property (p_hasd) else $error("Speed disable not stored");

    property p_eq;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_LINK_CTL2)
            |=> reg_rdata[20:17] == $past(eq_sts);
    endproperty
    a_eq: assert property (p_eq) else $error("Equalization status wrong");

    property p_rsvd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_DEV_CAP2)
            |=> reg_rdata[31:5] == 27'h0 && reg_rdata[4] == CPL_TO_DIS_OK;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("Capability 2 read wrong");

    property p_ptr_fn_tph;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && FUNC_NUM != 2'd0 && TPH_REQ_CAP) |=> reg_rdata[31:20] == 12'h300;
    endproperty
    a_ptr_fn_tph: assert property (p_ptr_fn_tph) else $error("Function TPH ptr wrong");

    property p_ptr_fn_ats;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_ERR_HDR && !ROUTING_ID_EN
            && FUNC_NUM != 2'd0 && !TPH_REQ_CAP && ATS_CAP) |=> reg_rdata[31:20] == 12'h3c0;
    endproperty
    a_ptr_fn_ats: assert property (p_ptr_fn_ats) else $error("Function ATS ptr wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr != cfg_regs_pkg::OFF_LINK_CTL
            && reg_addr != cfg_regs_pkg::OFF_DEV_CAP2 && reg_addr != cfg_regs_pkg::OFF_DEV_CTL2
            && reg_addr != cfg_regs_pkg::OFF_LINK_CAP2 && reg_addr != cfg_regs_pkg::OFF_LINK_CTL2
            && reg_addr != cfg_regs_pkg::OFF_ERR_HDR) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");

    property p_link_rsvd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_LINK_CTL)
            |=> reg_rdata[31:29] == 3'h0 && reg_rdata[27:26] == 2'h0 && reg_rdata[28] == SLOT_CLK_CFG
            && reg_rdata[15:8] == 8'h00 && reg_rdata[5:4] == 2'h0 && !reg_rdata[2];
    endproperty
    a_link_rsvd: assert property (p_link_rsvd) else $error("Link control reserved set");

    property p_devctl_rsvd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_DEV_CTL2)
            |=> reg_rdata[31:7] == 25'h000_0000 && !reg_rdata[5];
    endproperty
    a_devctl_rsvd: assert property (p_devctl_rsvd) else $error("Device control reserved set");

    property p_linkctl2_rsvd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_LINK_CTL2)
            |=> reg_rdata[31:22] == 10'h000 && !reg_rdata[16] && !reg_rdata[6];
    endproperty
    a_linkctl2_rsvd: assert property (p_linkctl2_rsvd) else $error("Link ctl2 reserved set");

    property p_linkcap2_rsvd;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_read && reg_addr == cfg_regs_pkg::OFF_LINK_CAP2)
            |=> reg_rdata[31:4] == 28'h000_0000 && !reg_rdata[0];
    endproperty
    a_linkcap2_rsvd: assert property (p_linkcap2_rsvd) else $error("Link cap2 reserved set");

    property p_atomic_rst;
        @(posedge clk)
        !reset_n
            |=> !atomic_req_en && reg_rdata == 32'h0000_0000;
    endproperty
    a_atomic_rst: assert property (p_atomic_rst) else $error("Atomic enable not reset");

    property p_hasd_rst;
        @(posedge clk)
        !reset_n
            |=> !hw_speed_disable;
    endproperty
    a_hasd_rst: assert property (p_hasd_rst) else $error("Speed disable not reset");

    property p_eq_rst;
        @(posedge clk)
        !reset_n
            |=> eq_sts == 4'h0 && !eq_req_flag;
    endproperty
    a_eq_rst: assert property (p_eq_rst) else $error("Equalization status not reset");

    property p_atomic_hold;
        @(posedge clk) disable iff (!reset_n)
        !(clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_DEV_CTL2)
            |=> $stable(atomic_req_en);
    endproperty
    a_atomic_hold: assert property (p_atomic_hold) else $error("Atomic enable moved");

    property p_hasd_hold;
        @(posedge clk) disable iff (!reset_n)
        !(clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_LINK_CTL2)
            |=> $stable(hw_speed_disable);
    endproperty
    a_hasd_hold: assert property (p_hasd_hold) else $error("Speed disable moved");

    property p_freeze_dev;
        @(posedge clk) disable iff (!reset_n)
        !clk_en
            |=> $stable(dev_ctl2) && $stable(atomic_req_en);
    endproperty
    a_freeze_dev: assert property (p_freeze_dev) else $error("Device control not frozen");

    property p_freeze_link;
        @(posedge clk) disable iff (!reset_n)
        !clk_en
            |=> $stable(link_ctl2) && $stable(link_ctl) && $stable(hw_speed_disable);
    endproperty
    a_freeze_link: assert property (p_freeze_link) else $error("Link control not frozen");

    property p_freeze_eq;
        @(posedge clk) disable iff (!reset_n)
        !clk_en
            |=> $stable(eq_sts) && $stable(eq_req_flag) && $stable(reg_rdata);
    endproperty
    a_freeze_eq: assert property (p_freeze_eq) else $error("Status not frozen");

    property p_eq_capture;
        @(posedge clk) disable iff (!reset_n)
        clk_en
            |=> eq_sts == $past(eq_status);
    endproperty
    a_eq_capture: assert property (p_eq_capture) else $error("Equalization not captured");

    property p_leq_set;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && eq_request)
            |=> eq_req_flag;
    endproperty
    a_leq_set: assert property (p_leq_set) else $error("Equalization request not set");

    property p_leq_clear;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && !eq_request && reg_write && reg_addr == cfg_regs_pkg::OFF_LINK_CTL2
            && reg_wdata[cfg_regs_pkg::BIT_LEQ_REQ]) |=> !eq_req_flag;
    endproperty
    a_leq_clear: assert property (p_leq_clear) else $error("Equalization request not cleared");

    property p_dev_write;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_DEV_CTL2)
            |=> dev_ctl2[31:7] == 25'h000_0000 && !dev_ctl2[5] && dev_ctl2[4:0] == $past(reg_wdata[4:0]);
    endproperty
    a_dev_write: assert property (p_dev_write) else $error("Device control write wrong");

    property p_link_write;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_write && reg_addr == cfg_regs_pkg::OFF_LINK_CTL)
            |=> link_ctl[31:8] == 24'h00_0000 && link_ctl[5:4] == 2'h0 && !link_ctl[2]
            && link_ctl[7:6] == $past(reg_wdata[7:6]) && link_ctl[1:0] == $past(reg_wdata[1:0]);
    endproperty
    a_link_write: assert property (p_link_write) else $error("Link control write wrong");

    property p_ro_write;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && reg_write && (reg_addr == cfg_regs_pkg::OFF_DEV_CAP2
            || reg_addr == cfg_regs_pkg::OFF_LINK_CAP2 || reg_addr == cfg_regs_pkg::OFF_ERR_HDR))
            |=> $stable(link_ctl) && $stable(dev_ctl2) && $stable(link_ctl2);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("Read-only write took effect");
endmodule // pcie_link_cap_config_regs

// ---- shared/cfg_regs_pkg.sv ----
// Package of offsets, fields, reset values and pointer codes for the link capability bank
package cfg_regs_pkg;
    localparam logic [11:0] OFF_LINK_CTL      = 12'h0090;
    localparam logic [11:0] OFF_DEV_CAP2      = 12'h00a4;
    localparam logic [11:0] OFF_DEV_CTL2      = 12'h00a8;
    localparam logic [11:0] OFF_LINK_CAP2     = 12'h00ac;
    localparam logic [11:0] OFF_LINK_CTL2     = 12'h00b0;
    localparam logic [11:0] OFF_ERR_HDR       = 12'h0100;
    // Writable masks
    localparam logic [31:0] MASK_LINK_CTL     = 32'h0000_00cb;
    localparam logic [31:0] MASK_DEV_CTL2     = 32'h0000_005f;
    localparam logic [31:0] MASK_LINK_CTL2    = 32'h0000_0fbf;
    localparam int          BIT_LEQ_REQ       = 21;
    // Reset values
    localparam logic [31:0] RST_LINK_CTL      = 32'h0000_0000;
    localparam logic [31:0] RST_DEV_CTL2      = 32'h0000_001f;
    localparam logic [31:0] RST_LINK_CTL2     = 32'h0000_0000;
    // Fields
    localparam int          POS_NEG_SPEED     = 16;
    localparam int          POS_NEG_WIDTH     = 20;
    localparam int          POS_SLOT_CLK      = 28;
    localparam int          POS_EQ_DONE       = 17;
    localparam int          POS_CAP_VER       = 16;
    localparam int          POS_NEXT_PTR      = 20;
    localparam logic [15:0] EXT_CAP_ID        = 16'h0001;
    localparam logic [3:0]  CAP_VERSION       = 4'h2;
    localparam logic [11:0] PTR_ROUTING       = 12'h0160;
    localparam logic [11:0] PTR_SECONDARY     = 12'h0280;
    localparam logic [11:0] PTR_TPH           = 12'h0300;
    localparam logic [11:0] PTR_ATS           = 12'h03c0;
    localparam logic [11:0] PTR_END           = 12'h0000;
    localparam logic [3:0]  SPEED_GEN3        = 4'h3;
endpackage

// ---- shared/cfg_bus_if.sv ----
// Interface carrying build-time configuration into the pointer selector
`timescale 1ns/1ps
interface cfg_bus_if;
    logic        routing_id_en;
    logic [1:0]  func_num;
    logic [3:0]  max_speed;
    logic        tph_req_cap;
    logic        ats_cap;
    logic [11:0] next_ptr;
    modport sel (input routing_id_en, func_num, max_speed, tph_req_cap, ats_cap,
                 output next_ptr);
    modport top (output routing_id_en, func_num, max_speed, tph_req_cap, ats_cap,
                 input next_ptr);
endinterface

// ---- logic/next_ptr_select.sv ----
// Next capability pointer selection for the error reporting header
`timescale 1ns/1ps
module next_ptr_select (
    cfg_bus_if.sel cfg
);
    always_comb begin
        if (cfg.routing_id_en) begin
            cfg.next_ptr = cfg_regs_pkg::PTR_ROUTING;
        end else if (cfg.func_num == 2'd0) begin
            if (cfg.max_speed == cfg_regs_pkg::SPEED_GEN3) begin
                cfg.next_ptr = cfg_regs_pkg::PTR_SECONDARY;
            end else if (cfg.tph_req_cap) begin
                cfg.next_ptr = cfg_regs_pkg::PTR_TPH;
            end else if (cfg.ats_cap) begin
                cfg.next_ptr = cfg_regs_pkg::PTR_ATS;
            end else begin
                cfg.next_ptr = cfg_regs_pkg::PTR_END;
            end
        end else if (cfg.tph_req_cap) begin
            cfg.next_ptr = cfg_regs_pkg::PTR_TPH;
        end else if (cfg.ats_cap) begin
            cfg.next_ptr = cfg_regs_pkg::PTR_ATS;
        end else begin
            cfg.next_ptr = cfg_regs_pkg::PTR_END;
        end
    end
endmodule // next_ptr_select

// ---- sim/link_train_model.sv ----
// Link training partner driving negotiated status and equalization results
`timescale 1ns/1ps
module link_train_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Bench control
    input  wire logic       step,
    input  wire logic       req,
    // Training status
    output logic      [3:0] neg_speed,
    output logic      [5:0] neg_width,
    output logic      [3:0] eq_status,
    output logic            eq_request
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            neg_speed  <= 4'h0;
            neg_width  <= 6'h00;
            eq_status  <= 4'h0;
            eq_request <= 1'b0;
        end else begin
            eq_request <= req;
            if (step) begin
                neg_speed <= 4'($urandom_range(1, 3));
                neg_width <= 6'(1 << $urandom_range(0, 3));
                eq_status <= 4'($urandom);
            end
        end
    end
endmodule // link_train_model

// ---- sim/pcie_link_cap_config_regs_tb.sv ----
// Self-checking bench for the link capability register bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module pcie_link_cap_config_regs_tb;
    localparam int             N  = 8;
    localparam logic [N-1:0]   RT = 8'h02;
    localparam logic [2*N-1:0] FN = 16'hc900;
    localparam logic [4*N-1:0] SP = 32'h3233_1233;
    localparam logic [N-1:0]   TP = 8'h14;
    localparam logic [N-1:0]   AT = 8'h2c;
    logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
    logic        reg_write = 1'b0, reg_read = 1'b0, step = 1'b0, req = 1'b0, leq = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] rdata [N];
    logic [31:0] got [N];
    logic [31:0] d;
    logic [N-1:0] atomic, hwsd;
    logic [3:0]  neg_speed, eq_status;
    logic [5:0]  neg_width;
    logic        eq_request;
    int          fails = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    for (genvar i = 0; i < N; i++) begin : g_cfg
        pcie_link_cap_config_regs #(.ROUTING_ID_EN(RT[i]), .FUNC_NUM(FN[2*i+:2]),
            .MAX_SPEED(SP[4*i+:4]), .TPH_REQ_CAP(TP[i]), .ATS_CAP(AT[i])) DUT (
            .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
            .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
            .reg_rdata(rdata[i]), .neg_speed(neg_speed), .neg_width(neg_width),
            .eq_status(eq_status), .eq_request(eq_request),
            .atomic_req_en(atomic[i]), .hw_speed_disable(hwsd[i]));
    end
    link_train_model partner (.clk(clk), .reset_n(reset_n), .step(step), .req(req),
        .neg_speed(neg_speed), .neg_width(neg_width), .eq_status(eq_status),
        .eq_request(eq_request));
    // Expected next pointer per configuration
    function automatic logic [11:0] exp_ptr(input int i);
        if (RT[i]) return 12'h160;
        if (FN[2*i+:2] == 2'd0) begin
            if (SP[4*i+:4] == 4'h3) return 12'h280;
            if (TP[i]) return 12'h300;
            if (AT[i]) return 12'h3c0;
        end else begin
            if (TP[i]) return 12'h300;
            if (AT[i]) return 12'h3c0;
        end
        return 12'h000;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 got = rdata;
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(84));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h100);
        for (int i = 0; i < N; i++) `CHK(got[i], {exp_ptr(i), 4'h2, 16'h0001})
        rd(12'h0a8);
        `CHK(got[0], 32'h0000_001f)
        `CHK(atomic[0], 1'b0)
        rd(12'h0b0);
        `CHK(got[0], 32'h0000_0000)
        `CHK(hwsd[0], 1'b0)
        rd(12'h0a4);
        `CHK(got[0], 32'h0000_0010)
        rd(12'h0ac);
        `CHK(got[0], 32'h0000_000e)
        rd(12'h0f0);
        `CHK(got[0], 32'h0000_0000)
        for (int k = 0; k < 24; k++) begin
            d = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0000_0000 : $urandom;
            step <= (k % 3 == 0);
            req <= (k % 5 == 2);
            leq = leq | (k % 5 == 2);
            wr(12'h090, d);
            step <= 1'b0;
            req <= 1'b0;
            wr(12'h0a8, d);
            wr(12'h0b0, d);
            leq = leq & ~d[21];
            wr(12'h100, d);
            `CHK(atomic[0], d[6])
            `CHK(hwsd[0], d[5])
            rd(12'h090);
            `CHK(got[0], {6'h00, neg_width, neg_speed, 8'h00, d[7:0] & 8'hcb})
            rd(12'h0a8);
            `CHK(got[0], d & 32'h0000_005f)
            rd(12'h0b0);
            `CHK(got[0], {10'h000, leq, eq_status, 1'b0, d[15:0] & 16'h0fbf})
            rd(12'h100);
            `CHK(got[0], {12'h280, 4'h2, 16'h0001})
        end
        clk_en <= 1'b0;
        wr(12'h0a8, ~d);
        clk_en <= 1'b1;
        rd(12'h0a8);
        `CHK(got[0], d & 32'h0000_005f)
        wr(12'h0b0, 32'h0020_0000);
        rd(12'h0b0);
        `CHK(got[0], {10'h000, 1'b0, eq_status, 17'h0_0000})
        req <= 1'b1;
        @(posedge clk);
        wr(12'h0b0, 32'h0020_0020);
        req <= 1'b0;
        rd(12'h0b0);
        `CHK(got[0], {10'h000, 1'b1, eq_status, 17'h0_0020})
        `CHK(hwsd[0], 1'b1)
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h0a8);
        `CHK(got[0], 32'h0000_001f)
        `CHK(atomic[0], 1'b0)
        `CHK(hwsd[0], 1'b0)
        rd(12'h0b0);
        `CHK(got[0], 32'h0000_0000)
        complete_run();
    end
endmodule // pcie_link_cap_config_regs_tb
